// ---- shared/led_dim_pkg.sv ----
// led dimming effect constants, register map and carrier types
// assumes a 250 MHz system clock and a host on a plain register port
package led_dim_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned FADE_STEP_MS = 20;
  localparam int unsigned FADE_STEP_CYC = FADE_STEP_MS * 1000 * CLK_MHZ;
  localparam int unsigned NUM_OUT = 10;
  localparam int unsigned NUM_GRP = 4;
  // register addresses
  localparam logic [7:0] ADDR_FADE_A = 8'h02;
  localparam logic [7:0] ADDR_FADE_B = 8'h03;
  localparam logic [7:0] ADDR_FADE_C = 8'h04;
  localparam logic [7:0] ADDR_FADE_D = 8'h05;
  localparam logic [7:0] ADDR_CFG_A_G0 = 8'h06;
  localparam logic [7:0] ADDR_CFG_B_G0 = 8'h07;
  localparam logic [7:0] ADDR_CFG_B_G1 = 8'h09;
  localparam logic [7:0] ADDR_CFG_B_G2 = 8'h0B;
  localparam logic [7:0] ADDR_CFG_B_G3 = 8'h0D;
  localparam logic [7:0] ADDR_TOUCH = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h21;
  localparam logic [7:0] REG_RESET = 8'h00;
  // field positions of the second config register
  localparam int unsigned F_RD_HI = 7;
  localparam int unsigned F_RD_LO = 6;
  localparam int unsigned F_LOW_HI = 5;
  localparam int unsigned F_LOW_LO = 3;
  localparam int unsigned F_BREATHE = 2;
  localparam int unsigned F_HOLD_HI = 1;
  localparam int unsigned F_HOLD_LO = 0;
  // fields of the first config register used by the sequencer
  localparam int unsigned F_RU_HI = 7;
  localparam int unsigned F_RU_LO = 6;
  localparam int unsigned F_HIGH_HI = 5;
  localparam int unsigned F_HIGH_LO = 3;
  // duty in percent, 0..100
  localparam logic [6:0] PWM_TOP = 7'h64;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RAMP_UP = 5'h02,
    ST_HOLD_HIGH = 5'h04,
    ST_RAMP_DOWN = 5'h08,
    ST_HOLD_LOW = 5'h10
  } seq_state_e;

  typedef struct packed {
    logic [1:0] ramp_up_select;
    logic [2:0] high_code;
    logic [1:0] ramp_down_select;
    logic [2:0] low_code;
    logic breathe;
    logic hold_high_select;
    logic hold_low_select;
  } grp_cfg_s;
endpackage

// ---- rtl/led_dim_seq.sv ----
// one output group: effect sequencer and active-low pwm
// assumes touch input is already synchronised and config is registered
`timescale 1ns/1ps
module led_dim_seq
  import led_dim_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_touch,
  input wire grp_cfg_s i_cfg,
  input wire logic [7:0] i_fade_a,
  input wire logic [7:0] i_fade_b,
  input wire logic [7:0] i_fade_c,
  input wire logic [7:0] i_fade_d,
  output logic o_drive_output_b,
  output seq_state_e o_state
);
  typedef struct packed {
    seq_state_e st;
    logic [31:0] step_cnt;
    logic [7:0] unit_cnt;
    logic [6:0] pwm_cnt;
    logic touch_d;
    logic out_b;
  } seq_s;

  seq_s s_r;
  seq_s s_nxt;

  function automatic logic [7:0] pick4(input logic [1:0] sel,
    input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
    input logic [7:0] d);
    case (sel)
      2'h0: pick4 = a;
      2'h1: pick4 = b;
      2'h2: pick4 = c;
      default: pick4 = d;
    endcase
  endfunction

  function automatic logic [6:0] low_pct(input logic [2:0] code);
    case (code)
      3'h0: low_pct = 7'h00;
      3'h1: low_pct = 7'h0A;
      3'h2: low_pct = 7'h14;
      3'h3: low_pct = 7'h1E;
      3'h4: low_pct = 7'h28;
      3'h5: low_pct = 7'h3C;
      3'h6: low_pct = 7'h50;
      default: low_pct = 7'h64;
    endcase
  endfunction

  function automatic logic [6:0] high_pct(input logic [2:0] code);
    case (code)
      3'h0: high_pct = 7'h64;
      3'h1: high_pct = 7'h5A;
      3'h2: high_pct = 7'h50;
      3'h3: high_pct = 7'h41;
      3'h4: high_pct = 7'h32;
      3'h5: high_pct = 7'h28;
      3'h6: high_pct = 7'h14;
      default: high_pct = 7'h00;
    endcase
  endfunction

  logic [7:0] period_units;
  logic [6:0] duty;
  logic [6:0] hi_d;
  logic [6:0] lo_d;
  logic unit_tick;

  always_comb
  begin
    hi_d = high_pct(i_cfg.high_code);
    lo_d = low_pct(i_cfg.low_code);
    case (s_r.st)
      ST_RAMP_UP: period_units = pick4(i_cfg.ramp_up_select,
        i_fade_a, i_fade_b, i_fade_c, i_fade_d);
      ST_HOLD_HIGH: period_units = i_cfg.hold_high_select ?
        i_fade_b : i_fade_a;
      ST_RAMP_DOWN: period_units = pick4(i_cfg.ramp_down_select,
        i_fade_a, i_fade_b, i_fade_c, i_fade_d);
      ST_HOLD_LOW: period_units = i_cfg.hold_low_select ?
        i_fade_b : i_fade_a;
      default: period_units = 8'h00;
    endcase
    // linear ramps interpolate by elapsed units; a period of zero jumps
    // signed, since the high level may be dimmer than the low one
    case (s_r.st)
      ST_RAMP_UP: duty = (period_units == 8'h00) ? hi_d : 7'(int'(lo_d) +
        (int'(hi_d) - int'(lo_d)) * int'(s_r.unit_cnt) /
        int'(period_units));
      ST_HOLD_HIGH: duty = hi_d;
      ST_RAMP_DOWN: duty = (period_units == 8'h00) ? lo_d : 7'(int'(hi_d) -
        (int'(hi_d) - int'(lo_d)) * int'(s_r.unit_cnt) /
        int'(period_units));
      ST_HOLD_LOW: duty = lo_d;
      default: duty = 7'h00;
    endcase
  end

  assign unit_tick = (s_r.step_cnt == 32'(FADE_STEP_CYC - 1));

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.touch_d = i_touch;
    s_nxt.pwm_cnt = (s_r.pwm_cnt == PWM_TOP - 7'h01) ? 7'h00 :
      7'(s_r.pwm_cnt + 7'h01);
    s_nxt.out_b = !(s_r.pwm_cnt < duty);
    if (s_r.st == ST_IDLE)
    begin
      s_nxt.step_cnt = 32'h0;
      s_nxt.unit_cnt = 8'h00;
      if (i_touch && !s_r.touch_d)
        s_nxt.st = ST_RAMP_UP;
    end
    else if (s_r.unit_cnt >= period_units)
    begin
      // 20 ms per unit of the chosen fade period
      s_nxt.step_cnt = 32'h0;
      s_nxt.unit_cnt = 8'h00;
      case (s_r.st)
        ST_RAMP_UP: s_nxt.st = ST_HOLD_HIGH;
        ST_HOLD_HIGH: s_nxt.st = ST_RAMP_DOWN;
        ST_RAMP_DOWN: s_nxt.st = ST_HOLD_LOW;
        ST_HOLD_LOW: s_nxt.st = (i_cfg.breathe && i_touch) ?
          ST_RAMP_UP : ST_IDLE;
        default: s_nxt.st = ST_IDLE;
      endcase
    end
    else if (unit_tick)
    begin
      s_nxt.step_cnt = 32'h0;
      s_nxt.unit_cnt = 8'(s_r.unit_cnt + 8'h01);
    end
    else
      s_nxt.step_cnt = 32'(s_r.step_cnt + 32'h1);
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      s_r.st <= ST_IDLE;
      s_r.step_cnt <= 32'h0;
      s_r.unit_cnt <= 8'h00;
      s_r.pwm_cnt <= 7'h00;
      s_r.touch_d <= 1'b0;
      s_r.out_b <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign o_drive_output_b = s_r.out_b;
  assign o_state = s_r.st;

  breathe_repeat_a: assert property (@(posedge i_sys_clk) disable iff
    (!i_rst_b) (s_r.st == ST_HOLD_LOW && s_r.unit_cnt >= period_units &&
    i_cfg.breathe && i_touch) |=> s_r.st == ST_RAMP_UP)
    else $error("breathing did not restart effect");
  no_repeat_a: assert property (@(posedge i_sys_clk) disable iff
    (!i_rst_b) (s_r.st == ST_HOLD_LOW && s_r.unit_cnt >= period_units &&
    !i_cfg.breathe) |=> s_r.st == ST_IDLE)
    else $error("effect repeated without breathing");
  low_duty_a: assert property (@(posedge i_sys_clk) disable iff
    (!i_rst_b) (s_r.st == ST_HOLD_LOW && i_cfg.low_code == 3'h5)
    |-> duty == 7'h3C)
    else $error("low target duty wrong");
  hold_high_time_a: assert property (@(posedge i_sys_clk) disable iff
    (!i_rst_b) (s_r.st == ST_HOLD_HIGH) |-> period_units ==
    (i_cfg.hold_high_select ? i_fade_b : i_fade_a))
    else $error("high hold period wrong");
  hold_low_time_a: assert property (@(posedge i_sys_clk) disable iff
    (!i_rst_b) (s_r.st == ST_HOLD_LOW) |-> period_units ==
    (i_cfg.hold_low_select ? i_fade_b : i_fade_a))
    else $error("low hold period wrong");
  ramp_down_time_a: assert property (@(posedge i_sys_clk) disable iff
    (!i_rst_b) (s_r.st == ST_RAMP_DOWN && i_cfg.ramp_down_select == 2'h3)
    |-> period_units == i_fade_d)
    else $error("ramp down period wrong");
  unit_step_a: assert property (@(posedge i_sys_clk) disable iff
    (!i_rst_b) (s_r.st != ST_IDLE && unit_tick &&
    s_r.unit_cnt < period_units) |=> s_r.unit_cnt == $past(s_r.unit_cnt)
    + 8'h01 && s_r.step_cnt == 32'h0)
    else $error("fade unit step wrong");
  pwm_out_a: assert property (@(posedge i_sys_clk) disable iff
    (!i_rst_b) (s_r.st == ST_HOLD_HIGH && duty == 7'h64) |=>
    !o_drive_output_b)
    else $error("full duty not driven low");
endmodule

// ---- rtl/led_dim_top.sv ----
// led dimming block: host registers, touch synchronisers, ten outputs
// assumes touch pins are asynchronous and host sits on the sys clock
`timescale 1ns/1ps
module led_dim_top
  import led_dim_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [NUM_OUT-1:0] i_touch,
  output logic [NUM_OUT-1:0] o_drive_output_b
);
  typedef struct packed {
    logic [3:0][7:0] fade;
    logic [3:0][7:0] cfg_a;
    logic [3:0][7:0] cfg_b;
    logic [7:0] rdata;
    logic [NUM_OUT-1:0] t1;
    logic [NUM_OUT-1:0] t2;
    logic [NUM_OUT-1:0] t3;
    logic [NUM_OUT-1:0] touch;
  } top_s;

  top_s s_r;
  top_s s_nxt;
  reg_req_s req;
  grp_cfg_s [3:0] gcfg;
  seq_state_e [3:0] gst;
  logic [3:0] gtouch;
  logic [3:0][2:0] gout_b;

  // group index of a config register, 4 means not this kind
  function automatic logic [2:0] grp_of(input logic [7:0] a,
    input logic second);
    logic [7:0] base;
    logic [7:0] off;
    base = second ? ADDR_CFG_B_G0 : ADDR_CFG_A_G0;
    off = 8'(a - base);
    if (a >= base && off <= 8'h06 && !off[0])
      grp_of = 3'(off >> 1);
    else
      grp_of = 3'h4;
  endfunction

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  always_comb
  begin
    logic [2:0] ga;
    logic [2:0] gb;
    s_nxt = s_r;
    ga = grp_of(req.addr, 1'b0);
    gb = grp_of(req.addr, 1'b1);
    // three stages; a level counts once stages two and three agree
    s_nxt.t1 = i_touch;
    s_nxt.t2 = s_r.t1;
    s_nxt.t3 = s_r.t2;
    for (int i = 0; i < NUM_OUT; i++)
      if (s_r.t2[i] == s_r.t3[i])
        s_nxt.touch[i] = s_r.t3[i];
    if (req.wr)
    begin
      if (req.addr >= ADDR_FADE_A && req.addr <= ADDR_FADE_D)
        s_nxt.fade[2'(req.addr - ADDR_FADE_A)] = req.wdata;
      if (ga != 3'h4)
        s_nxt.cfg_a[ga[1:0]] = req.wdata;
      if (gb != 3'h4)
        s_nxt.cfg_b[gb[1:0]] = req.wdata;
    end
    s_nxt.rdata = 8'h00;
    if (req.rd)
    begin
      if (req.addr >= ADDR_FADE_A && req.addr <= ADDR_FADE_D)
        s_nxt.rdata = s_r.fade[2'(req.addr - ADDR_FADE_A)];
      else if (ga != 3'h4)
        s_nxt.rdata = s_r.cfg_a[ga[1:0]];
      else if (gb != 3'h4)
        s_nxt.rdata = s_r.cfg_b[gb[1:0]];
      else if (req.addr == ADDR_TOUCH)
        s_nxt.rdata = s_r.touch[7:0];
      else if (req.addr == ADDR_STATUS)
        s_nxt.rdata = {2'b00, s_r.touch[9:8], gst[3] != ST_IDLE,
          gst[2] != ST_IDLE, gst[1] != ST_IDLE, gst[0] != ST_IDLE};
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      s_r.fade <= '0;
      s_r.cfg_a <= '0;
      s_r.cfg_b <= '0;
      s_r.rdata <= REG_RESET;
      s_r.t1 <= '0;
      s_r.t2 <= '0;
      s_r.t3 <= '0;
      s_r.touch <= '0;
    end
    else
      s_r <= s_nxt;
  end

  // a group shares one sequencer: any touched button in it starts it
  assign gtouch = {|s_r.touch[9:7], |s_r.touch[6:4], |s_r.touch[3:1],
    s_r.touch[0]};

  for (genvar g = 0; g < NUM_GRP; g++)
  begin : g_grp
    assign gcfg[g] = '{
      ramp_up_select: s_r.cfg_a[g][F_RU_HI:F_RU_LO],
      high_code: s_r.cfg_a[g][F_HIGH_HI:F_HIGH_LO],
      ramp_down_select: s_r.cfg_b[g][F_RD_HI:F_RD_LO],
      low_code: s_r.cfg_b[g][F_LOW_HI:F_LOW_LO],
      breathe: s_r.cfg_b[g][F_BREATHE],
      hold_high_select: s_r.cfg_b[g][F_HOLD_HI],
      hold_low_select: s_r.cfg_b[g][F_HOLD_LO]};
    led_dim_seq u_seq (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_touch(gtouch[g]),
      .i_cfg(gcfg[g]),
      .i_fade_a(s_r.fade[0]),
      .i_fade_b(s_r.fade[1]),
      .i_fade_c(s_r.fade[2]),
      .i_fade_d(s_r.fade[3]),
      .o_drive_output_b(gout_b[g][0]),
      .o_state(gst[g])
    );
    assign gout_b[g][2:1] = {2{gout_b[g][0]}};
  end

  assign o_drive_output_b = {gout_b[3], gout_b[2], gout_b[1],
    gout_b[0][0]};
  assign o_rdata = s_r.rdata;

  cfg_reset_a: assert property (@(posedge i_sys_clk) $rose(i_rst_b)
    |-> s_r.cfg_b == '0)
    else $error("config not zero after reset");
  cfg_write_a: assert property (@(posedge i_sys_clk) disable iff
    (!i_rst_b) (i_wr && i_addr == ADDR_CFG_B_G2) |=> s_r.cfg_b[2] ==
    $past(i_wdata))
    else $error("config write lost");
  group_map_a: assert property (@(posedge i_sys_clk) disable iff
    (!i_rst_b) o_drive_output_b[9] == o_drive_output_b[7] &&
    o_drive_output_b[3] == o_drive_output_b[1])
    else $error("group outputs disagree");
endmodule

// ---- testbench/led_bank.sv ----
// partner model: ten leds hanging on the active-low drive outputs
// assumes one led per output, lit while its output is low
`timescale 1ns/1ps
module led_bank
(
  input wire logic i_sys_clk,
  input wire logic i_clear,
  input wire logic [9:0] i_drive_output_b,
  output logic [9:0][15:0] o_on_count
);
  // leds only sink current, so they obey no rule of their own
  always_ff @(posedge i_sys_clk)
  begin
    for (int i = 0; i < 10; i++)
    begin
      if (i_clear)
        o_on_count[i] <= 16'h0000;
      else if (!i_drive_output_b[i])
        o_on_count[i] <= o_on_count[i] + 16'h0001;
    end
  end
endmodule

// ---- testbench/led_dim_ramp_down_config_test.sv ----
// self-checking bench for the led dimming block
// assumes fade periods of 0 or 1 unit; one unit outlasts the whole run
`timescale 1ns/1ps
module led_dim_ramp_down_config_test;
  import led_dim_pkg::*;
  logic i_sys_clk, i_rst_b, i_wr, i_rd, clear;
  logic [7:0] i_addr, i_wdata, o_rdata;
  logic [9:0] i_touch, o_drive_output_b;
  logic [9:0][15:0] on_count;
  logic [15:0] cnt;
  int stray;
  int fails = 0;
  int total_checks = 0;
  int first_out [4] = '{0, 1, 4, 7};
  int last_out [4] = '{0, 3, 6, 9};
  led_dim_top uut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_touch(i_touch),
    .o_drive_output_b(o_drive_output_b));
  led_bank leds (.i_sys_clk(i_sys_clk), .i_clear(clear),
    .i_drive_output_b(o_drive_output_b), .o_on_count(on_count));
  initial
  begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic reset_dut();
    @(posedge i_sys_clk);
    i_rst_b <= 1'b0;
    i_touch <= 10'h000;
    repeat (20) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
  endtask
  // reset, program one group, hold its first button, count 1000 cycles
  task automatic run_case(input int g, input logic [31:0] fades,
    input logic [7:0] ca, input logic [7:0] cb);
    logic [9:0] m;
    reset_dut();
    m = 10'h000;
    for (int k = first_out[g]; k <= last_out[g]; k++)
      m[k] = 1'b1;
    for (int k = 0; k < 4; k++)
      reg_write(ADDR_FADE_A + 8'(k), fades[8*k +: 8]);
    reg_write(ADDR_CFG_A_G0 + 8'(2*g), ca);
    reg_write(ADDR_CFG_B_G0 + 8'(2*g), cb);
    @(posedge i_sys_clk) i_touch <= 10'h001 << first_out[g];
    // long settle: synchroniser plus all one-cycle states are far shorter
    repeat (1000) @(posedge i_sys_clk);
    clear <= 1'b1;
    @(posedge i_sys_clk) clear <= 1'b0;
    stray = 0;
    repeat (1000)
    begin
      @(negedge i_sys_clk);
      if ((o_drive_output_b & ~m) !== ~m)
        stray++;
      else if ((o_drive_output_b & m) !== m && (o_drive_output_b & m) !== 0)
        stray++;
    end
    @(posedge i_sys_clk);
    #1 cnt = on_count[first_out[g]];
  endtask
  task automatic test_regs();
    logic [7:0] d;
    reset_dut();
    @(posedge i_sys_clk);
    #1 check({6'h00, o_drive_output_b}, 16'h03FF);
    for (int g = 0; g < 4; g++)
    begin
      reg_read(ADDR_CFG_B_G0 + 8'(2*g), d);
      check({8'h00, d}, 16'h0000);
      reg_write(ADDR_CFG_B_G0 + 8'(2*g), 8'hA5 ^ 8'(g));
      reg_read(ADDR_CFG_B_G0 + 8'(2*g), d);
      check({8'h00, d}, {8'h00, 8'hA5 ^ 8'(g)});
    end
    // read data stand one cycle only, then the port falls back to zero
    @(posedge i_sys_clk);
    #1 check({8'h00, o_rdata}, 16'h0000);
    reg_write(ADDR_FADE_C, 8'h3C);
    reg_read(ADDR_FADE_C, d);
    check({8'h00, d}, 16'h003C);
    reg_write(8'hF0, 8'h5A);
    reg_read(8'hF0, d);
    check({8'h00, d}, 16'h0000);
    $display("test regs done");
  endtask
  // the selected period alone is one unit long, so the led stays lit; the last case selects a zero period and stays dark
  task automatic test_ramp_down_select();
    logic [31:0] fd [5] = '{32'h1, 32'h100, 32'h10000, 32'h1000000,
      32'h1000000};
    logic [7:0] ca [5] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] cb [5] = '{8'h3B, 8'h78, 8'hB8, 8'hF8, 8'hB8};
    logic [15:0] ex [5] = '{16'd1000, 16'd1000, 16'd1000, 16'd1000, 16'd0};
    for (int k = 0; k < 5; k++)
    begin
      run_case(k % 4, fd[k], ca[k], cb[k]);
      check(cnt, ex[k]);
      check(16'(stray), 16'h0000);
    end
    $display("test ramp down select done");
  endtask
  task automatic test_hold_high();
    run_case(0, 32'h100, 8'h00, 8'h02);
    check(cnt, 16'd1000);
    run_case(0, 32'h100, 8'h00, 8'h00);
    check(cnt, 16'd0);
    run_case(0, 32'h100, 8'h28, 8'h02);
    check(cnt, 16'd400);
    $display("test hold high done");
  endtask
  // low hold on the one-unit period shows the floor duty exactly
  task automatic test_floor_codes();
    int duty [8] = '{0, 10, 20, 30, 40, 60, 80, 100};
    for (int c = 0; c < 8; c++)
    begin
      run_case(c % 4, 32'h100, 8'h00, {2'b00, 3'(c), 3'b001});
      check(cnt, 16'(10 * duty[c]));
      check(16'(stray), 16'h0000);
    end
    $display("test floor codes done");
  endtask
  task automatic test_breathing();
    run_case(2, 32'h0, 8'h00, 8'h3C);
    check(cnt, 16'd1000);
    run_case(2, 32'h0, 8'h00, 8'h38);
    check(cnt, 16'd0);
    $display("test breathing done");
  endtask
  initial
  begin
    i_rst_b = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_touch = 10'h000;
    clear = 1'b0;
    test_regs();
    test_ramp_down_select();
    test_hold_high();
    test_floor_codes();
    test_breathing();
    report_and_stop();
  end
  // about 37k cycles expected; allow a little over twice that
  initial
  begin
    #320000;
    fails++;
    report_and_stop();
  end
endmodule
